// [pies_core_model.sv]
`timescale 1ns/1ps

module pies_core_model (
	input  wire logic                      clock,
	input  wire logic                      srst,
	input  wire logic                      live,
	input  wire logic                      leave,
	input  wire logic                      core_irq_request,
	input  wire pies_pkg::pies_vector_type vector,
	output logic                           core_accept,
	output logic                           core_return,
	output int                             takes
);
	import pies_pkg::*;

	// ********
	// core side: accept while live, count vector jumps
	// ********
	always_ff @(posedge clock) begin
		core_accept <= 1'b0;
		core_return <= leave;
		if (srst) begin
			takes <= 0;
		end else begin
			if (vector.take === 1'b1 && vector.addr === 16'h0004) begin
				takes <= takes + 1;
			end
			if (live && core_irq_request && !core_accept) begin
				core_accept <= 1'b1;
			end
		end
	end
endmodule : pies_core_model

// [pies_pkg.sv]
package pies_pkg;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_EN_BASE    = 8'h04;
	localparam logic [7:0] OFF_EN_STEP    = 8'h04;
	localparam logic [7:0] OFF_STATUS0    = 8'h24;
	localparam logic [7:0] OFF_PIN_SEL    = 8'h28;
	localparam logic [7:0] OFF_EVT_STATUS = 8'h2C;
	localparam logic [7:0] OFF_EVT_MASK   = 8'h30;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_GIE_BIT   = 7;
	localparam int CTRL_PERIPHERAL_IRQ_GATE_BIT  = 6;
	localparam int CTRL_EDGE_BIT  = 0;
	localparam int ST0_TMR0_BIT   = 5;
	localparam int ST0_IOC_BIT    = 4;
	localparam int ST0_EXT_BIT    = 0;
	localparam int EN2_CMP2_BIT   = 1;
	localparam int EVT_TMR0_BIT   = 0;
	localparam int EVT_EXT_BIT    = 1;
	localparam int EVT_VECTOR_BIT = 2;

	// ************************************************************
	// sizes, masks and reset values
	// ************************************************************
	localparam int              NUM_EN        = 8;
	localparam int              NUM_PIN_FLAGS = 40;
	localparam int              NUM_EVT       = 3;
	localparam logic [2:0]      SIZE_WORD     = 3'h2;
	localparam logic [0:7][7:0] EN_MASK       = {8'h31, 8'hC1, 8'h43, 8'h33, 8'h03, 8'hF1, 8'h03, 8'h31};
	localparam logic [7:0]      EN_RESET      = 8'h00;
	localparam logic [2:0]      PIN_SEL_RESET = 3'h0;
	localparam logic [2:0]      EVT_RESET     = 3'h0;
	localparam logic [15:0]     VECTOR_ADDR   = 16'h0004;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] offset;
	} pies_dphase_type;

	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_irq_gate;
		logic edge_rising;
	} pies_ctrl_type;

	typedef struct packed {
		logic        take;
		logic [15:0] addr;
	} pies_vector_type;

	typedef logic [7:1][7:0] pies_flags_type;

	localparam pies_ctrl_type CTRL_RESET = '{global_irq_enable: 1'b0, peripheral_irq_gate: 1'b0, edge_rising: 1'b1};

endpackage : pies_pkg

// [pies_tb_top.sv]
`timescale 1ns/1ps

module pies_tb_top;
	import pies_pkg::*;

	// ********
	// bench signals
	// ********
	typedef struct {logic [7:0] off, wd, ex;} pies_row_type;
	logic            clock = 1'b0, srst = 1'b1, hwrite = 1'b0, tzo = 1'b0, live = 1'b0, leave = 1'b0;
	logic [1:0]      htrans = 2'h0;
	logic [31:0]     haddr = '0, hwdata = '0, hrdata, rd, hrdata_s, rd_s;
	logic            hreadyout, hresp, req, irq, acc, ret;
	logic [39:0]     ppc = '0;
	logic [7:0]      pins = '0;
	pies_flags_type  pf = '0;
	pies_vector_type vec;
	int              failures = 0, compares = 0, cyc = 0, takes;
	pies_row_type    rows [11] = '{'{8'h08, 8'hFF, 8'hC1}, '{8'h0C, 8'hFF, 8'h43}, '{8'h10, 8'hFF, 8'h33},
		'{8'h14, 8'hFF, 8'h03}, '{8'h18, 8'hFF, 8'hF1}, '{8'h1C, 8'hFF, 8'h03}, '{8'h20, 8'hFF, 8'h31},
		'{8'h08, 8'h3E, 8'h00}, '{8'h18, 8'h0E, 8'h00}, '{8'h34, 8'hFF, 8'h00}, '{8'h04, 8'hFF, 8'h31}};

	always #5 clock = ~clock;

	pies_top #(.LARGE_MEMBER(1'b1)) u_dut (.clock(clock), .srst(srst), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .periph_flags(pf), .per_pin_change_flags(ppc),
		.timer_zero_overflow(tzo), .ext_pins(pins), .core_accept(acc), .core_return(ret),
		.core_irq_request(req), .vector(vec), .irq(irq));

	pies_top #(.LARGE_MEMBER(1'b0)) u_small (.clock(clock), .srst(srst), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata_s),
		.hreadyout(), .hresp(), .periph_flags(pf), .per_pin_change_flags(ppc), .timer_zero_overflow(tzo),
		.ext_pins(pins), .core_accept(1'b0), .core_return(1'b0), .core_irq_request(), .vector(), .irq());

	pies_core_model u_core (.clock(clock), .srst(srst), .live(live), .leave(leave), .core_irq_request(req),
		.vector(vec), .core_accept(acc), .core_return(ret), .takes(takes));

	task automatic results();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		htrans <= 2'h2;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		rd_s = hrdata_s;
		chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
		chk("hreadyout", 32'h0000_0001, {31'h0000_0000, hreadyout});
	endtask : bus

	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk(nm, {24'h00_0000, e}, rd);
	endtask : rchk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			results();
		end
	end

	// ********
	// tests
	// ********
	initial begin
		tick(12);
		srst <= 1'b0;
		tick(2);
		rchk("control reset", 8'h00, 8'h01);
		for (int n = 1; n < 8; n++) rchk("enable reset", 8'(4 + 4 * n), 8'h00);
		for (int i = 0; i < 11; i++) begin
			bus(rows[i].off, 1'b1, rows[i].wd);
			rchk("register", rows[i].off, rows[i].ex);
		end
		rchk("enable two large", 8'h0C, 8'h43);
		chk("enable two small", 32'h0000_0041, rd_s);
		$display("done registers");
		tzo <= 1'b1;
		tick(1);
		tzo <= 1'b0;
		ppc <= 40'h80_0000_0000;
		tick(1);
		rchk("status0 set", 8'h24, 8'h30);
		bus(8'h24, 1'b1, 8'h00);
		rchk("status0 clear", 8'h24, 8'h10);
		ppc <= '0;
		tick(1);
		rchk("summary clear", 8'h24, 8'h00);
		bus(8'h28, 1'b1, 8'h03);
		pins <= 8'hF7;
		tick(2);
		rchk("other pins", 8'h24, 8'h00);
		pins <= 8'hFF;
		tick(2);
		rchk("ext flag", 8'h24, 8'h01);
		pins <= 8'h00;
		tick(3);
		rchk("ext sticky", 8'h24, 8'h01);
		bus(8'h24, 1'b1, 8'h00);
		rchk("ext cleared", 8'h24, 8'h00);
		$display("done status");
		rchk("event status", 8'h2C, 8'h03);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		bus(8'h30, 1'b1, 8'h01);
		tick(2);
		chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
		bus(8'h2C, 1'b1, 8'h01);
		tick(2);
		chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
		rchk("event w1c", 8'h2C, 8'h02);
		$display("done events");
		bus(8'h00, 1'b1, 8'h81);
		tzo <= 1'b1;
		tick(1);
		tzo <= 1'b0;
		tick(3);
		chk("request global only", 32'h0000_0001, {31'h0000_0000, req});
		bus(8'h24, 1'b1, 8'h00);
		pf[1] <= 8'h01;
		bus(8'h08, 1'b1, 8'h01);
		tick(3);
		chk("request gate shut", 32'h0000_0000, {31'h0000_0000, req});
		bus(8'h00, 1'b1, 8'hC1);
		tick(3);
		chk("request held", 32'h0000_0001, {31'h0000_0000, req});
		live <= 1'b1;
		tick(4);
		live <= 1'b0;
		chk("vector taken", 32'h0000_0001, takes);
		chk("request dropped", 32'h0000_0000, {31'h0000_0000, req});
		rchk("global cleared", 8'h00, 8'h41);
		leave <= 1'b1;
		tick(1);
		leave <= 1'b0;
		tick(3);
		rchk("global restored", 8'h00, 8'hC1);
		$display("done request");
		srst <= 1'b1;
		tick(2);
		srst <= 1'b0;
		tick(2);
		rchk("enable after reset", 8'h0C, 8'h00);
		chk("request after reset", 32'h0000_0000, {31'h0000_0000, req});
		$display("done reset");
		results();
	end
endmodule : pies_tb_top

// [pies_top.sv]
`timescale 1ns/1ps

// Summary of operation
// RQ1: peripheral requests need the peripheral gate set
// RQ2: enable one: bits 7, 6, 0 only
// RQ3: enable two: bits 6, 1, 0 only
// RQ4: comparator two enable only on larger member
// RQ5: enable three: bits 5, 4, 1, 0
// RQ6: enable four: bits 1, 0 only
// RQ7: enable five: bits 7-4 and 0
// RQ8: enable six: bits 1, 0 only
// RQ9: enable seven: bits 5, 4, 0
// RQ10: enables read/write, reset zero, gaps read zero
// RQ11: timer0 overflow flag sticky until written zero
// RQ12: external pin flag sticky until software clears
// RQ13: change summary is read-only OR of pins
// RQ14: external pin chosen by pin select register
// RQ15: flags set regardless of any enable
// RQ16: enable zero sources need only global enable
// RQ17: accepted request clears global enable, vector 0004h
// RQ18: request is a level while enabled flag pending
module pies_top #(
	parameter bit LARGE_MEMBER = 1'b1
) (
	input  wire logic                     clock,
	input  wire logic                     srst,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	input  wire pies_pkg::pies_flags_type periph_flags,
	input  wire logic [39:0]              per_pin_change_flags,
	input  wire logic                     timer_zero_overflow,
	input  wire logic [7:0]               ext_pins,
	input  wire logic                     core_accept,
	input  wire logic                     core_return,
	output logic                          core_irq_request,
	output pies_pkg::pies_vector_type     vector,
	output logic                          irq
);
	import pies_pkg::*;

	// ************************************************************
	// storage
	// ************************************************************
	pies_dphase_type dphase;
	pies_ctrl_type   ctrl;
	logic [7:0]      en [0:NUM_EN-1];
	logic            timer_zero_overflow_flag;
	logic            ext_pin_irq_flag;
	logic            pin_change_summary_flag;
	logic [2:0]      ext_pin_select_reg;
	logic [2:0]      evt_status;
	logic [2:0]      evt_mask;
	logic            pin_prev;
	logic            pin_primed;
	logic            pin_now;
	logic            ext_edge;
	logic            pend0;
	logic            pend_periph;
	logic            accept;
	logic [2:0]      evt_set;
	logic [7:0]      wdata;

	// ************************************************************
	// decoding helpers
	// ************************************************************
	function automatic logic wr_hit(input pies_dphase_type d, input logic [7:0] off);
		return d.valid && d.write && (d.offset == off);
	endfunction : wr_hit

	function automatic logic [7:0] en_offset(input int idx);
		return 8'(OFF_EN_BASE + 8'(idx) * OFF_EN_STEP);
	endfunction : en_offset

	function automatic logic [7:0] en_mask(input int idx);
		logic [7:0] m;
		m = EN_MASK[idx];
		if (idx == 2 && !LARGE_MEMBER) begin
			m[EN2_CMP2_BIT] = 1'b0; // RQ4
		end
		return m;
	endfunction : en_mask

	function automatic logic [7:0] status0_byte();
		logic [7:0] s;
		s = 8'h00;
		s[ST0_TMR0_BIT] = timer_zero_overflow_flag;
		s[ST0_IOC_BIT]  = pin_change_summary_flag;
		s[ST0_EXT_BIT]  = ext_pin_irq_flag;
		return s;
	endfunction : status0_byte

	function automatic logic [7:0] read_byte(input logic [7:0] off);
		logic [7:0] r;
		r = 8'h00;
		if (off == OFF_CTRL) begin
			r[CTRL_GIE_BIT]  = ctrl.global_irq_enable;
			r[CTRL_PERIPHERAL_IRQ_GATE_BIT] = ctrl.peripheral_irq_gate;
			r[CTRL_EDGE_BIT] = ctrl.edge_rising;
		end
		for (int i = 0; i < NUM_EN; i++) begin
			if (off == en_offset(i)) begin
				r = en[i]; // RQ10
			end
		end
		if (off == OFF_STATUS0) begin
			r = status0_byte();
		end
		if (off == OFF_PIN_SEL) begin
			r = {5'h00, ext_pin_select_reg};
		end
		if (off == OFF_EVT_STATUS) begin
			r = {5'h00, evt_status};
		end
		if (off == OFF_EVT_MASK) begin
			r = {5'h00, evt_mask};
		end
		return r;
	endfunction : read_byte

	// ************************************************************
	// bus slave
	// ************************************************************
	assign wdata = hwdata[7:0];

	always_ff @(posedge clock) begin
		if (srst) begin
			dphase <= '0;
		end else begin
			dphase.valid  <= hsel && htrans[1] && hready && (hsize == SIZE_WORD);
			dphase.write  <= hwrite;
			dphase.offset <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h00_0000) begin
			hrdata <= {24'h00_0000, read_byte(haddr[7:0])};
		end else begin
			hrdata <= 32'h0000_0000;
		end
	end

	always_ff @(posedge clock) begin
		hreadyout <= 1'b1;
		hresp     <= 1'b0;
	end

	// ************************************************************
	// control and enables
	// ************************************************************
	assign accept = core_irq_request && core_accept;

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl <= CTRL_RESET;
		end else if (accept) begin
			ctrl.global_irq_enable <= 1'b0; // RQ17
		end else if (wr_hit(dphase, OFF_CTRL)) begin
			ctrl.global_irq_enable         <= wdata[CTRL_GIE_BIT];
			ctrl.peripheral_irq_gate        <= wdata[CTRL_PERIPHERAL_IRQ_GATE_BIT];
			ctrl.edge_rising <= wdata[CTRL_EDGE_BIT];
		end else if (core_return) begin
			ctrl.global_irq_enable <= 1'b1;
		end
	end

	for (genvar i = 0; i < NUM_EN; i++) begin : g_en
		always_ff @(posedge clock) begin
			if (srst) begin
				en[i] <= EN_RESET; // RQ10
			end else if (wr_hit(dphase, en_offset(i))) begin
				en[i] <= wdata & en_mask(i); // RQ2 RQ3 RQ5 RQ6 RQ7 RQ8 RQ9
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ext_pin_select_reg <= PIN_SEL_RESET;
		end else if (wr_hit(dphase, OFF_PIN_SEL)) begin
			ext_pin_select_reg <= wdata[2:0];
		end
	end

	// ************************************************************
	// external pin edge
	// ************************************************************
	assign pin_now = ext_pins[ext_pin_select_reg]; // RQ14

	always_ff @(posedge clock) begin
		if (srst) begin
			pin_prev   <= 1'b0;
			pin_primed <= 1'b0;
		end else begin
			pin_prev   <= pin_now;
			pin_primed <= 1'b1;
		end
	end

	assign ext_edge = pin_primed && (ctrl.edge_rising ? (pin_now && !pin_prev) : (!pin_now && pin_prev));

	// ************************************************************
	// status register zero
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			timer_zero_overflow_flag <= 1'b0;
		end else if (timer_zero_overflow) begin
			timer_zero_overflow_flag <= 1'b1; // RQ11 RQ15
		end else if (wr_hit(dphase, OFF_STATUS0)) begin
			timer_zero_overflow_flag <= wdata[ST0_TMR0_BIT]; // RQ11
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ext_pin_irq_flag <= 1'b0;
		end else if (ext_edge) begin
			ext_pin_irq_flag <= 1'b1; // RQ12 RQ15
		end else if (wr_hit(dphase, OFF_STATUS0)) begin
			ext_pin_irq_flag <= wdata[ST0_EXT_BIT]; // RQ12
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pin_change_summary_flag <= 1'b0;
		end else begin
			pin_change_summary_flag <= |per_pin_change_flags; // RQ13
		end
	end

	// ************************************************************
	// request to the core
	// ************************************************************
	always_comb begin
		pend0       = |(en[0] & status0_byte());
		pend_periph = 1'b0;
		for (int i = 1; i < NUM_EN; i++) begin
			pend_periph = pend_periph | (|(en[i] & periph_flags[i]));
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			core_irq_request <= 1'b0;
		end else begin
			core_irq_request <= ctrl.global_irq_enable && !accept && (pend0 || (ctrl.peripheral_irq_gate && pend_periph)); // RQ1 RQ16 RQ18
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			vector <= '{take: 1'b0, addr: VECTOR_ADDR};
		end else begin
			vector <= '{take: accept, addr: VECTOR_ADDR}; // RQ17
		end
	end

	// ************************************************************
	// event status, mask and interrupt line
	// ************************************************************
	always_comb begin
		evt_set                 = EVT_RESET;
		evt_set[EVT_TMR0_BIT]   = timer_zero_overflow;
		evt_set[EVT_EXT_BIT]    = ext_edge;
		evt_set[EVT_VECTOR_BIT] = accept;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			evt_status <= EVT_RESET;
		end else if (wr_hit(dphase, OFF_EVT_STATUS)) begin
			evt_status <= evt_set | (evt_status & ~wdata[2:0]);
		end else begin
			evt_status <= evt_set | evt_status;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			evt_mask <= EVT_RESET;
		end else if (wr_hit(dphase, OFF_EVT_MASK)) begin
			evt_mask <= wdata[2:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_status & evt_mask);
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	sequence s_request_accepted;
		core_irq_request && core_accept;
	endsequence

	sequence s_vector_taken;
		vector.take && (vector.addr == VECTOR_ADDR) && !ctrl.global_irq_enable;
	endsequence

	sequence s_tmr0_kept;
		timer_zero_overflow || (timer_zero_overflow_flag && !wr_hit(dphase, OFF_STATUS0));
	endsequence

	sequence s_ext_kept;
		ext_edge || (ext_pin_irq_flag && !wr_hit(dphase, OFF_STATUS0));
	endsequence

	a_req_needs_gie: assert property (core_irq_request |-> $past(ctrl.global_irq_enable)) // RQ18
		else $error("request without global enable");

	a_periph_gate: assert property (core_irq_request && !$past(pend0) |-> $past(ctrl.peripheral_irq_gate)) // RQ1
		else $error("peripheral request without gate");

	a_enable0_path: assert property (ctrl.global_irq_enable && pend0 && !core_accept |=> core_irq_request) // RQ16
		else $error("enable zero source did not request");

	a_vector_entry: assert property (s_request_accepted |=> s_vector_taken) // RQ17
		else $error("accept did not vector to 0004h");

	a_enable_gaps: assert property (((en[1] & ~EN_MASK[1]) == 8'h00) && ((en[4] & ~EN_MASK[4]) == 8'h00)
		&& ((en[6] & ~EN_MASK[6]) == 8'h00)) // RQ10
		else $error("unimplemented enable bit set");

	a_cmp2_absent: assert property (!LARGE_MEMBER |-> !en[2][EN2_CMP2_BIT]) // RQ4
		else $error("comparator two enable present");

	a_tmr0_sticky: assert property (s_tmr0_kept |=> timer_zero_overflow_flag) // RQ11
		else $error("timer0 flag not held");

	a_ext_flag_set: assert property (ext_edge |=> ext_pin_irq_flag) // RQ12
		else $error("external pin flag not set");

	a_ioc_summary: assert property (##1 pin_change_summary_flag == $past(|per_pin_change_flags)) // RQ13
		else $error("change summary mismatch");

	a_flag_no_gate: assert property (timer_zero_overflow && !ctrl.global_irq_enable && !ctrl.peripheral_irq_gate |=> timer_zero_overflow_flag) // RQ15
		else $error("flag blocked by enables");

	a_irq_level: assert property (irq == $past(|(evt_status & evt_mask))) // RQ18
		else $error("interrupt line mismatch");

	a_ext_sticky: assert property (s_ext_kept |=> ext_pin_irq_flag) // RQ12
		else $error("external pin flag not held");

	a_periph_path: assert property (ctrl.global_irq_enable && ctrl.peripheral_irq_gate && pend_periph && !core_accept |=> core_irq_request) // RQ1
		else $error("gated peripheral source did not request");

	a_vector_pulse: assert property (vector.take |=> !vector.take) // RQ17
		else $error("vector pulse longer than one cycle");

	a_accept_drops: assert property (s_request_accepted |=> !core_irq_request) // RQ17
		else $error("request held after accept");

	a_summary_ro: assert property (wr_hit(dphase, OFF_STATUS0) && !(|per_pin_change_flags) |=> !pin_change_summary_flag) // RQ13
		else $error("change summary written by software");

endmodule : pies_top
